// *** bench/tb.sv ***
// Testbench joining host controller and memory control end over the link
`timescale 1ns/1ps
module tb
    import xmem_ctrl_pkg::*;
;
    logic       ref_clk;
    logic       nrst;
    logic       cfg_addr4;
    logic       cmd_valid;
    logic [7:0] cmd_op;
    logic       hw_reset_req;
    logic       quad_mode;
    logic       cmd_ready;
    logic       cmd_done;
    logic       addr4_mode;
    logic       deep_pd;
    logic       busy;
    logic [7:0] flag_status;
    int         mismatches;
    int         total_checks;

    xmem_link_if link ();

    xmem_host_ctrl #(.EXIT_WAIT(20)) i_xmem_host_ctrl (
        .ref_clk(ref_clk), .nrst(nrst), .link(link), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .hw_reset_req(hw_reset_req), .quad_mode(quad_mode), .cmd_ready(cmd_ready), .cmd_done(cmd_done));

    // Long busy so that later opcodes land inside the write
    xmem_dev_ctrl #(.PD_ENTRY_CYCLES(4), .PD_EXIT_CYCLES(4), .BUSY_CYCLES(40)) i_xmem_dev_ctrl (
        .link(link), .nrst(nrst), .cfg_addr4(cfg_addr4), .addr4_mode(addr4_mode), .deep_pd(deep_pd),
        .busy(busy), .op_abort(), .cur_addr(), .cur_op(), .op_valid(), .flag_status(flag_status));

    xmem_ctrl_properties i_xmem_ctrl_properties (
        .ref_clk(ref_clk), .nrst(nrst), .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi),
        .reset_n(link.reset_n), .wide_mode(link.wide_mode), .addr4_mode(addr4_mode),
        .deep_pd(deep_pd), .busy(busy), .flag_status(flag_status));

    // Reference clock, 20 ns
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Issue one opcode and wait for its completion pulse
    task automatic send(input logic [7:0] op);
        int n;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        for (n = 0; n < 3000; n++) begin
            @(posedge ref_clk);
            if (cmd_done === 1'b1) break;
        end
    endtask

    // Request a pulse on the reset pin
    task automatic hw_pulse();
        @(posedge ref_clk);
        hw_reset_req <= 1'b1;
        repeat (RST_PULSE_CYC + 4) @(posedge ref_clk);
        hw_reset_req <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask

    task automatic t_reset_state();
        check("addr4 after reset", addr4_mode, 8'h00);
        check("pd after reset", deep_pd, 8'h00);
        check("flag after reset", flag_status, FLAG_RESET);
    endtask

    task automatic t_addr_mode();
        send(OP_ENTER_4B);
        check("addr4 on enter", addr4_mode, 8'h01);
        check("flag on enter", flag_status, 8'h81);
        send(OP_EXIT_4B);
        check("addr4 on exit", addr4_mode, 8'h00);
        check("flag on exit", flag_status, 8'h80);
    endtask

    task automatic t_hw_reset();
        send(OP_ENTER_4B);
        hw_pulse();
        check("addr4 after pin reset", addr4_mode, 8'h00);
        check("flag after pin reset", flag_status, FLAG_RESET);
        quad_mode <= 1'b1;
        send(OP_ENTER_4B);
        hw_pulse();
        check("addr4 pin ignored in quad", addr4_mode, 8'h01);
        quad_mode <= 1'b0;
        send(OP_EXIT_4B);
    endtask

    task automatic t_soft_reset();
        cfg_addr4 <= 1'b1;
        send(OP_RST_MEM);
        check("addr4 lone reset memory", addr4_mode, 8'h00);
        send(OP_RST_EN);
        send(OP_RST_MEM);
        check("addr4 from config", addr4_mode, 8'h01);
        check("ready after soft reset", flag_status[7], 8'h01);
        cfg_addr4 <= 1'b0;
        send(OP_RST_EN);
        send(OP_RST_MEM);
        check("addr4 dropped by soft reset", addr4_mode, 8'h00);
    endtask

    task automatic t_power_down();
        send(OP_PD_ENTER);
        send(OP_RD_FLAG);
        check("pd entered", deep_pd, 8'h01);
        send(OP_ENTER_4B);
        check("enter ignored in pd", addr4_mode, 8'h00);
        send(OP_PD_EXIT);
        send(OP_RD_FLAG);
        check("pd left", deep_pd, 8'h00);
        send(OP_ENTER_4B);
        check("enter after recovery", addr4_mode, 8'h01);
        send(OP_EXIT_4B);
        send(OP_PD_ENTER);
        send(OP_RD_FLAG);
        send(OP_RST_EN);
        send(OP_RST_MEM);
        check("pd ended by soft reset", deep_pd, 8'h00);
        send(OP_PD_ENTER);
        send(OP_RD_FLAG);
        hw_pulse();
        check("pd ended by pin reset", deep_pd, 8'h00);
    endtask

    task automatic t_busy_refusals();
        send(OP_WR_STATUS);
        check("busy on write", busy, 8'h01);
        send(OP_PD_ENTER);
        send(OP_RST_EN);
        send(OP_RST_MEM);
        check("reset enable refused", busy, 8'h01);
        repeat (3) send(OP_RD_FLAG);
        check("write finished", busy, 8'h00);
        check("ready flag", flag_status, 8'h80);
        check("pd refused while busy", deep_pd, 8'h00);
    endtask

    // Cut a hang short
    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        nrst = 1'b0;
        cfg_addr4 = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        hw_reset_req = 1'b0;
        quad_mode = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset_state();
        t_addr_mode();
        t_hw_reset();
        t_soft_reset();
        t_power_down();
        t_busy_refusals();
        report_and_stop();
    end
endmodule

// *** bench/xmem_ctrl_properties.sv ***
// Checker for the serial link between host controller and memory control end
`timescale 1ns/1ps
module xmem_ctrl_properties
    import xmem_ctrl_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic       mosi,
    input wire logic       reset_n,
    input wire logic       wide_mode,
    input wire logic       addr4_mode,
    input wire logic       deep_pd,
    input wire logic       busy,
    input wire logic [7:0] flag_status
);
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] prev;

    // Bit count within a select, cleared while deselected
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    // Opcode shifter, MSB first
    always_ff @(posedge sck) begin
        if (!cs_n) begin
            sh <= {sh[6:0], mosi};
        end
    end

    // Opcode of the previous complete select
    always_ff @(negedge sck) begin
        if (cnt == 4'h8) begin
            prev <= sh;
        end
    end

    a_flag_tracks_addr4: assert property (@(posedge sck) disable iff (!nrst)
        flag_status[0] == addr4_mode) else $error("flag bit 0 differs from address mode");
    a_ready_bit_busy: assert property (@(posedge sck) disable iff (!nrst)
        flag_status[7] == !busy) else $error("ready bit differs from busy");
    a_enter_sets_addr4: assert property (@(negedge sck) disable iff (!nrst)
        (cnt == 4'h8 && sh == OP_ENTER_4B && !deep_pd && !$past(deep_pd)) |-> addr4_mode && flag_status[0])
        else $error("enter opcode did not select four byte address");
    a_exit_clears_addr4: assert property (@(negedge sck) disable iff (!nrst)
        (cnt == 4'h8 && sh == OP_EXIT_4B && !deep_pd && !$past(deep_pd)) |-> !addr4_mode && !flag_status[0])
        else $error("exit opcode did not restore three byte address");
    a_rst_needs_enable: assert property (@(negedge sck) disable iff (!nrst)
        (cnt == 4'h8 && sh == OP_RST_MEM && prev != OP_RST_EN) |=> addr4_mode == $past(addr4_mode))
        else $error("reset memory acted without reset enable");
    a_soft_rst_ready: assert property (@(negedge sck) disable iff (!nrst)
        (cnt == 4'h8 && sh == OP_RST_MEM && prev == OP_RST_EN && !$past(busy)) |=> flag_status[7] && !deep_pd)
        else $error("software reset left device not ready");
    a_pd_blocks_cmd: assert property (@(posedge sck) disable iff (!nrst)
        (deep_pd && $past(deep_pd) && !$past(addr4_mode)) |-> !addr4_mode)
        else $error("command acted during deep power down");
    a_pd_not_busy: assert property (@(posedge sck) disable iff (!nrst)
        $rose(deep_pd) |-> !$past(busy)) else $error("deep power down entered while busy");
    a_hw_reset_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!reset_n && !$past(reset_n) && cs_n && !wide_mode) |-> !addr4_mode && !deep_pd && !busy)
        else $error("hardware reset did not clear state");
    a_rst_pin_select: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(reset_n) |-> cs_n) else $error("reset pin lowered while selected");
endmodule

// *** hdl/xmem_dev_ctrl.sv ***
// Memory side command interpreter for address mode, power down and resets
`timescale 1ns/1ps
module xmem_dev_ctrl
    import xmem_ctrl_pkg::*;
#(
    parameter int PD_ENTRY_CYCLES = PD_ENTRY_CYC,
    parameter int PD_EXIT_CYCLES  = PD_EXIT_CYC,
    parameter int BUSY_CYCLES     = BUSY_CYC
) (
    xmem_link_if.device     link,
    input  wire logic       nrst,
    input  wire logic       cfg_addr4,
    output logic            addr4_mode,
    output logic            deep_pd,
    output logic            busy,
    output logic            op_abort,
    output logic [31:0]     cur_addr,
    output logic [7:0]      cur_op,
    output logic            op_valid,
    output logic [7:0]      flag_status
);
    initial begin
        if (PD_ENTRY_CYCLES < 1 || PD_EXIT_CYCLES < 1 || BUSY_CYCLES < 1 ||
            PD_EXIT_CYCLES > 65535 || PD_ENTRY_CYCLES > 65535 || BUSY_CYCLES > 65535) begin
            $error("xmem_dev_ctrl: cycle counts out of range");
        end
    end

    typedef enum {ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} phase_t;
    phase_t      phase;
    logic [7:0]  shreg;
    logic [5:0]  bit_cnt;
    logic [7:0]  op;
    logic        rst_armed;
    logic        pd_pending;
    logic [15:0] pd_cnt;
    logic [15:0] rec_cnt;
    logic [15:0] busy_cnt;
    logic        sw_rst;
    logic [7:0]  out_byte;
    logic        cs_d;
    logic        hw_rst_n;
    logic        rst_n;
    logic [7:0]  next_byte;
    logic        cmd_end;
    logic        accept_ok;
    logic        cfg_meta;
    logic        cfg_sync;
    logic        busy_reg_wr;

    // Reset pin counts only when not in quad mode and chip select is high
    assign hw_rst_n = link.reset_n | link.wide_mode | ~link.cs_n;
    assign rst_n    = nrst & hw_rst_n;
    assign next_byte = {shreg[6:0], link.mosi};
    assign cmd_end  = (phase == ST_OPCODE) && (bit_cnt == 6'd7);
    assign accept_ok = (rec_cnt == 16'h0000);
    assign flag_status = {~busy, 6'h00, addr4_mode};
    assign busy = (busy_cnt != 16'h0000);
    assign cur_op = op;

    // Command shift and phase sequencing on the rising link clock
    always_ff @(posedge link.sck or negedge rst_n) begin
        if (!rst_n) begin
            phase    <= ST_OPCODE;
            shreg    <= 8'h00;
            bit_cnt  <= 6'd0;
            op       <= 8'h00;
            cur_addr <= 32'h0000_0000;
            op_valid <= 1'b0;
        end else if (link.cs_n) begin
            phase    <= ST_OPCODE;
            bit_cnt  <= 6'd0;
            op_valid <= 1'b0;
        end else begin
            shreg   <= next_byte;
            bit_cnt <= bit_cnt + 6'd1;
            case (phase)
                ST_OPCODE: begin
                    if (bit_cnt == 6'd7) begin
                        bit_cnt <= 6'd0;
                        op      <= next_byte;
                        if (!accept_ok || (deep_pd && next_byte != OP_PD_EXIT &&
                            next_byte != OP_RST_EN && next_byte != OP_RST_MEM)) begin
                            op    <= 8'h00; // Refused opcode must not start a write
                            phase <= ST_IGNORE;
                        end else if (has_addr(next_byte)) begin
                            phase <= ST_ADDR;
                        end else begin
                            phase <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    cur_addr <= {cur_addr[30:0], link.mosi};
                    if (int'(bit_cnt) == ((is_op4(op) || addr4_mode) ? ADDR4_BITS : ADDR3_BITS) - 1) begin
                        bit_cnt <= 6'd0;
                        op_valid <= 1'b1;
                        phase <= (op == OP_FREAD_4B || op == OP_FREAD_3B) ? ST_DUMMY : ST_DATA;
                    end
                end
                ST_DUMMY: begin
                    if (int'(bit_cnt) == FAST_DUMMY - 1) begin
                        bit_cnt <= 6'd0;
                        phase   <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (bit_cnt == 6'd7) begin
                        bit_cnt  <= 6'd0;
                        cur_addr <= cur_addr + 32'h1;
                    end
                end
                ST_IGNORE: bit_cnt <= 6'd0;
                default:   phase <= ST_OPCODE;
            endcase
        end
    end

    // Write opcodes start busy once chip select rises; tracked by sampling cs
    always_ff @(posedge link.sck or negedge rst_n) begin
        if (!rst_n) begin
            cs_d <= 1'b1;
        end else begin
            cs_d <= link.cs_n;
        end
    end

    // Config level comes from the system clock; two flops before use
    always_ff @(posedge link.sck or negedge rst_n) begin
        if (!rst_n) begin
            cfg_meta <= 1'b0;
            cfg_sync <= 1'b0;
        end else begin
            cfg_meta <= cfg_addr4;
            cfg_sync <= cfg_meta;
        end
    end

    // Address mode, power down and reset arming on each opcode
    always_ff @(posedge link.sck or negedge rst_n) begin
        if (!rst_n) begin
            addr4_mode <= ADDR4_RESET;
            rst_armed  <= 1'b0;
            pd_pending <= 1'b0;
            deep_pd    <= 1'b0;
            sw_rst     <= 1'b0;
        end else begin
            sw_rst <= 1'b0;
            if (sw_rst) begin
                addr4_mode <= cfg_sync;
                rst_armed  <= 1'b0;
                pd_pending <= 1'b0;
                deep_pd    <= 1'b0;
            end else if (!link.cs_n && cmd_end && accept_ok) begin
                rst_armed <= 1'b0;
                if (deep_pd) begin
                    if (next_byte == OP_PD_EXIT) begin
                        deep_pd <= 1'b0;
                    end else if (next_byte == OP_RST_EN) begin
                        rst_armed <= 1'b1;
                    end
                end else begin
                    case (next_byte)
                        OP_ENTER_4B: addr4_mode <= 1'b1;
                        OP_EXIT_4B:  addr4_mode <= 1'b0;
                        OP_PD_ENTER: pd_pending <= ~busy;
                        OP_RST_EN:   rst_armed  <= ~(busy && busy_reg_wr);
                        default:     ;
                    endcase
                end
                if (next_byte == OP_RST_MEM && rst_armed) begin
                    sw_rst <= 1'b1;
                end
            end else if (pd_pending && pd_cnt == 16'(PD_ENTRY_CYCLES)) begin
                pd_pending <= 1'b0;
                deep_pd    <= 1'b1;
            end
        end
    end

    // Entry delay, exit recovery and busy timers
    always_ff @(posedge link.sck or negedge rst_n) begin
        if (!rst_n) begin
            pd_cnt   <= 16'h0000;
            rec_cnt  <= 16'h0000;
            busy_cnt    <= 16'h0000;
            busy_reg_wr <= 1'b0;
            op_abort    <= 1'b0;
        end else begin
            op_abort <= sw_rst && busy;
            pd_cnt   <= pd_pending ? pd_cnt + 16'h1 : 16'h0000;
            if (!link.cs_n && cmd_end && deep_pd && accept_ok && next_byte == OP_PD_EXIT) begin
                rec_cnt <= 16'(PD_EXIT_CYCLES);
            end else if (rec_cnt != 16'h0000) begin
                rec_cnt <= rec_cnt - 16'h1;
            end
            if (sw_rst) begin
                busy_cnt <= 16'h0000;
            end else if (link.cs_n && !cs_d && is_write(op) && !deep_pd) begin
                busy_cnt    <= 16'(BUSY_CYCLES);
                busy_reg_wr <= (op == OP_WR_STATUS || op == OP_WR_NVCFG);
            end else if (busy_cnt != 16'h0000) begin
                busy_cnt <= busy_cnt - 16'h1;
            end
        end
    end

    // Flag bit 7 repeats on the output after the flag read opcode, as the bit count stays zero
    always_ff @(negedge link.sck or negedge rst_n) begin
        if (!rst_n) begin
            out_byte     <= 8'h00;
            link.miso    <= 1'b0;
            link.miso_oe <= 1'b0;
        end else if (link.cs_n) begin
            link.miso_oe <= 1'b0;
        end else if (phase == ST_IGNORE && op == OP_RD_FLAG && !deep_pd) begin
            link.miso_oe <= 1'b1;
            link.miso    <= (bit_cnt == 6'd0) ? flag_status[7] : out_byte[7];
            out_byte     <= (bit_cnt == 6'd0) ? {flag_status[6:0], 1'b0} : {out_byte[6:0], 1'b0};
        end
    end
endmodule

// *** hdl/xmem_host_ctrl.sv ***
// Host side controller issuing single opcodes and driving the reset pin
`timescale 1ns/1ps
module xmem_host_ctrl
    import xmem_ctrl_pkg::*;
#(
    parameter int DIV       = HOST_DIV,
    parameter int EXIT_WAIT = PD_EXIT_REF_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    xmem_link_if.host       link,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_op,
    input  wire logic       hw_reset_req,
    input  wire logic       quad_mode,
    output logic            cmd_ready,
    output logic            cmd_done
);
    initial begin
        if (DIV < 1 || DIV > 255 || EXIT_WAIT < 1 || EXIT_WAIT > 65535) begin
            $error("xmem_host_ctrl: parameter out of range");
        end
    end

    typedef enum {H_IDLE, H_SHIFT, H_GAP, H_RESET, H_WAIT} hstate_t;
    hstate_t     state;
    logic [7:0]  div_cnt;
    logic [7:0]  sh;
    logic [3:0]  bits;
    logic [15:0] wait_cnt;

    assign cmd_ready = (state == H_IDLE);
    assign link.wide_mode = quad_mode;
    assign link.reset_n_oe = ~quad_mode;

    // One opcode, then hold select high; long wait after power down exit
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state        <= H_IDLE;
            div_cnt      <= 8'h00;
            sh           <= 8'h00;
            bits         <= 4'h0;
            wait_cnt     <= 16'h0000;
            link.sck     <= 1'b0;
            link.cs_n    <= 1'b1;
            link.mosi    <= 1'b0;
            link.reset_n <= 1'b1;
            cmd_done     <= 1'b0;
        end else begin
            cmd_done <= 1'b0;
            case (state)
                H_IDLE: begin
                    link.sck <= 1'b0;
                    if (hw_reset_req && !quad_mode) begin
                        link.reset_n <= 1'b0;
                        wait_cnt     <= 16'(RST_PULSE_CYC);
                        state        <= H_RESET;
                    end else if (cmd_valid) begin
                        link.cs_n <= 1'b0;
                        link.mosi <= cmd_op[7];
                        sh        <= {cmd_op[6:0], 1'b0};
                        bits      <= 4'h0;
                        div_cnt   <= 8'h00;
                        wait_cnt  <= (cmd_op == OP_PD_EXIT) ? 16'(EXIT_WAIT) : 16'h0004;
                        state     <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (div_cnt == 8'(DIV - 1)) begin
                        div_cnt  <= 8'h00;
                        link.sck <= ~link.sck;
                        if (link.sck) begin
                            link.mosi <= sh[7];
                            sh        <= {sh[6:0], 1'b0};
                            if (bits == 4'h8) begin
                                state <= H_GAP;
                            end
                        end else begin
                            bits <= bits + 4'h1;
                        end
                    end else begin
                        div_cnt <= div_cnt + 8'h01;
                    end
                end
                H_GAP: begin
                    link.cs_n <= 1'b1;
                    state     <= H_WAIT;
                end
                H_RESET: begin
                    if (wait_cnt == 16'h0000) begin
                        link.reset_n <= 1'b1;
                        wait_cnt     <= 16'h0004;
                        div_cnt      <= 8'h00;
                        state        <= H_WAIT;
                    end else begin
                        wait_cnt <= wait_cnt - 16'h1;
                    end
                end
                // Idle link clocks with select high keep the device timers running
                H_WAIT: begin
                    if (div_cnt == 8'(DIV - 1)) begin
                        div_cnt <= 8'h00;
                        if (wait_cnt == 16'h0000 && !link.sck) begin
                            cmd_done <= 1'b1;
                            state    <= H_IDLE;
                        end else begin
                            link.sck <= ~link.sck;
                            if (link.sck) begin
                                wait_cnt <= wait_cnt - 16'h1;
                            end
                        end
                    end else begin
                        div_cnt <= div_cnt + 8'h01;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule

// *** pkg/xmem_ctrl_pkg.sv ***
// Shared constants for the address mode, power down and reset control link
// Contract
// - Enter command selects 32-bit address, sets flag bit0
// - Exit command restores 24-bit address, clears bit0
// - Any reset drops back to 3-byte addressing; software reset here loads cfg_addr4 instead
// - Default address phase is 24 bits
// - Dedicated 4-byte opcodes always take 32-bit address
// - Other commands use 32 bits only when enabled
// - DCh sector, 21h 4kB, 5Ch 32kB erase
// - Address bits captured on rising clock edge
// - Read address increments after each output byte
// - Power down entered after entry delay elapses
// - Power down ignores all but exit and resets
// - Power down refused while erase or write busy
// - Exit recovery time elapses before commands accepted
// - Resets end power down; start in standby
// - Reset enable then reset memory restores defaults
// - Software reset aborts write, program or erase
// - Reset effective once flag bit7 reads ready
// - Reset enable refused during register writes
// - Host leaves execute in place before reset
// - Hardware reset only while chip select high
// - Hardware reset clears registers, aborts operations
// - Shared reset pin acts only in single/dual
package xmem_ctrl_pkg;
    localparam logic [7:0] OP_ENTER_4B  = 8'hB7;
    localparam logic [7:0] OP_EXIT_4B   = 8'hE9;
    localparam logic [7:0] OP_READ_4B   = 8'h13;
    localparam logic [7:0] OP_FREAD_4B  = 8'h0C;
    localparam logic [7:0] OP_PROG_4B   = 8'h12;
    localparam logic [7:0] OP_SE_4B     = 8'hDC;
    localparam logic [7:0] OP_SS4K_4B   = 8'h21;
    localparam logic [7:0] OP_SS32K_4B  = 8'h5C;
    localparam logic [7:0] OP_READ_3B   = 8'h03;
    localparam logic [7:0] OP_FREAD_3B  = 8'h0B;
    localparam logic [7:0] OP_PROG_3B   = 8'h02;
    localparam logic [7:0] OP_SE_3B     = 8'hD8;
    localparam logic [7:0] OP_SS4K_3B   = 8'h20;
    localparam logic [7:0] OP_SS32K_3B  = 8'h52;
    localparam logic [7:0] OP_PD_ENTER  = 8'hB9;
    localparam logic [7:0] OP_PD_EXIT   = 8'hAB;
    localparam logic [7:0] OP_RST_EN    = 8'h66;
    localparam logic [7:0] OP_RST_MEM   = 8'h99;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_WR_NVCFG  = 8'hB1;
    localparam logic [7:0] OP_RD_FLAG   = 8'h70;
    localparam int FLAG_ADDR4_BIT = 0;
    localparam int FLAG_READY_BIT = 7;
    localparam int ADDR3_BITS     = 24;
    localparam int ADDR4_BITS     = 32;
    localparam int FAST_DUMMY     = 8;
    localparam int LINK_CLK_NS    = 64;
    localparam int PD_ENTRY_NS    = 3000;
    localparam int PD_EXIT_NS     = 30000;
    localparam int BUSY_NS        = 2000;
    localparam int PD_ENTRY_CYC = (PD_ENTRY_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
    localparam int PD_EXIT_CYC  = (PD_EXIT_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
    localparam int BUSY_CYC     = (BUSY_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
    localparam int REF_CLK_NS   = 20;
    localparam int HOST_DIV     = 2;
    localparam int PD_EXIT_REF_CYC = (PD_EXIT_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int RST_PULSE_NS = 100;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam logic [7:0] FLAG_RESET = 8'h80;
    localparam logic       ADDR4_RESET = 1'b0;

    // True for opcodes that always carry a four byte address
    function automatic logic is_op4(input logic [7:0] op);
        return op == OP_READ_4B || op == OP_FREAD_4B || op == OP_PROG_4B ||
               op == OP_SE_4B || op == OP_SS4K_4B || op == OP_SS32K_4B;
    endfunction

    // True for opcodes followed by an address phase
    function automatic logic has_addr(input logic [7:0] op);
        return is_op4(op) || op == OP_READ_3B || op == OP_FREAD_3B ||
               op == OP_PROG_3B || op == OP_SE_3B || op == OP_SS4K_3B || op == OP_SS32K_3B;
    endfunction

    // True for opcodes that start a self timed write or erase
    function automatic logic is_write(input logic [7:0] op);
        return op == OP_PROG_4B || op == OP_PROG_3B || op == OP_SE_4B || op == OP_SE_3B ||
               op == OP_SS4K_4B || op == OP_SS4K_3B || op == OP_SS32K_4B || op == OP_SS32K_3B ||
               op == OP_WR_STATUS || op == OP_WR_NVCFG;
    endfunction
endpackage

// *** pkg/xmem_link_if.sv ***
// Serial link between host controller and memory control end
`timescale 1ns/1ps
interface xmem_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic reset_n;
    logic reset_n_oe;
    logic wide_mode;

    modport device (
        input  sck,
        input  cs_n,
        input  mosi,
        output miso,
        output miso_oe,
        input  reset_n,
        input  reset_n_oe,
        input  wide_mode
    );
    modport host (
        output sck,
        output cs_n,
        output mosi,
        input  miso,
        input  miso_oe,
        output reset_n,
        output reset_n_oe,
        output wide_mode
    );
endinterface
